// file: src/dtt_defs.svh
// Purpose: Constants for the die temperature trip and alert logic
// Assumes: 10 MHz system clock
// Notes:   Offsets and layouts as defines; types live in the package
`ifndef DTT_DEFS_SVH
`define DTT_DEFS_SVH

// ********************************************
// Timing
// ********************************************
`define DTT_CLK_HZ          10000000
`define DTT_EVAL_PERIOD_S   1
`define DTT_EVAL_CYCLES     (`DTT_CLK_HZ * `DTT_EVAL_PERIOD_S)

// ********************************************
// Temperatures and codes
// ********************************************
`define DTT_TEMP_W          9
`define DTT_CATA_TEMP       9'sd120
`define DTT_REPORT_MAX      8'h7f
`define DTT_REPORT_OFF      8'hff
`define DTT_ROUTE_SMI       1'b0
`define DTT_ROUTE_SCI       1'b1

`endif

// file: src/dtt_eval_timer.sv
// Purpose: Once-per-interval tick generator for the over-temperature compare
// Assumes: Synchronous active-high reset
// Notes:   Period is a parameter so simulation can shorten it
`timescale 1ns/1ns
`include "dtt_defs.svh"

module dtt_eval_timer
#(
	parameter int unsigned PERIOD = `DTT_EVAL_CYCLES
)
(
	input  wire logic clk_sys,
	input  wire logic reset,
	output logic      tick
);
	import dtt_pkg::*;

	// ********************************************
	// Counter
	// ********************************************
	logic [31:0] cnt_reg;   // Cycles since last tick
	logic [31:0] cnt_next;
	logic        tick_reg;
	logic        tick_next;

	// Wrap at PERIOD-1 and pulse for one cycle
	always_comb
	begin
		tick_next = 1'b0;
		cnt_next  = cnt_reg + 32'h1;
		if (cnt_reg >= PERIOD - 1)
		begin
			cnt_next  = 32'h0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			cnt_reg  <= 32'h0;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;

	// Tick spacing: after a tick, none in the next cycle when period exceeds one
	chk_tick_single: assert property (@(posedge clk_sys) disable iff (reset)
		(tick && PERIOD > 1) |=> !tick) else $error("tick not single");
endmodule

// file: src/dtt_pkg.sv
// Purpose: Types for the die temperature trip and alert logic
// Assumes: dtt_defs.svh supplies the numeric constants
// Notes:   Trip configuration travels as one packed struct
package dtt_pkg;

	// Signed 9-bit temperature, one degree per step
	typedef logic signed [8:0] dtt_temp_t;

	// Per-trip configuration: enable and SMI/SCI route select
	typedef struct packed
	{
		logic enable;
		logic route_sci;
	} dtt_trip_cfg_s;

	// Alert pulses out toward the interrupt fabric
	typedef struct packed
	{
		logic smi;
		logic sci;
	} dtt_alert_s;

endpackage

// file: src/dtt_trip_alert.sv
// Purpose: Die temperature hold, trip detection, alert routing, report byte, hot pin
// Assumes: Inputs synchronous to clk_sys; synchronous active-high reset
// Notes:   Configuration bits are plain ports, there is no register bus
//
// Functional notes
// - Hold temperature as 9 bits, 1 degree.
// - Three trips: cool, hot, catastrophic ascending.
// - Falling through cool may interrupt.
// - Rising through hot may interrupt.
// - No interrupt on other crossing directions.
// - Cool and hot trips each route alert to SMI/SCI.
// - Catastrophic crossing forces immediate power down.
// - Catastrophic trip fixed at 120, unprogrammable.
// - Temperature reported regardless of alert configuration.
// - When enabled, forward temperature to both units.
// - Report byte 0..127, or ff if disabled.
// - Hot pin asserted when temperature exceeds limit.
// - Limit comparison evaluated once each second.
// - Hot pin is open-drain, pulls low only.
`timescale 1ns/1ns
`include "dtt_defs.svh"

module dtt_trip_alert
#(
	parameter int unsigned EVAL_CYCLES = `DTT_EVAL_CYCLES
)
(
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	input  wire logic                  sensor_enable,
	input  wire logic                  sample_valid,
	input  wire dtt_pkg::dtt_temp_t    sample_temp,
	input  wire dtt_pkg::dtt_temp_t    cool_trip,
	input  wire dtt_pkg::dtt_temp_t    hot_trip,
	input  wire dtt_pkg::dtt_trip_cfg_s cool_cfg,
	input  wire dtt_pkg::dtt_trip_cfg_s hot_cfg,
	input  wire dtt_pkg::dtt_temp_t    hot_pin_limit_value,
	input  wire logic                  report_enable,
	output dtt_pkg::dtt_temp_t         temp_value,
	output dtt_pkg::dtt_alert_s        alert,
	output logic                       power_down,
	output logic [7:0]                 smbus_temp_byte,
	output logic [7:0]                 espi_temp_byte,
	output logic                       overtemp_alert_n_out,
	output logic                       overtemp_alert_n_oe
);
	import dtt_pkg::*;

	// ********************************************
	// Helpers
	// ********************************************

	// Report byte: clamp to 0..127, ff while sensor is off
	function automatic logic [7:0] report_byte(input logic en, input dtt_temp_t t);
		logic [7:0] b;
		b = `DTT_REPORT_OFF;
		if (en)
		begin
			if (t < 0)
				b = 8'h00;
			else if (t > $signed({1'b0, `DTT_REPORT_MAX}))
				b = `DTT_REPORT_MAX;
			else
				b = t[7:0];
		end
		return b;
	endfunction

	// Route an alert event to SMI or SCI
	function automatic dtt_alert_s route(input logic ev, input dtt_trip_cfg_s c);
		dtt_alert_s a;
		a.smi = ev && c.enable && (c.route_sci == `DTT_ROUTE_SMI);
		a.sci = ev && c.enable && (c.route_sci == `DTT_ROUTE_SCI);
		return a;
	endfunction

	// ********************************************
	// Evaluation tick
	// ********************************************
	logic eval_tick; // One pulse per evaluation interval

	dtt_eval_timer #(.PERIOD(EVAL_CYCLES)) u_timer
	(
		.clk_sys (clk_sys),
		.reset   (reset),
		.tick    (eval_tick)
	);

	// ********************************************
	// State
	// ********************************************
	dtt_temp_t  temp_reg;       // Held signed temperature
	dtt_temp_t  temp_next;
	logic       have_reg;       // A valid sample has been held
	logic       have_next;
	dtt_alert_s alert_reg;      // Routed alert pulses
	dtt_alert_s alert_next;
	logic       pdown_reg;      // Sticky power-down request
	logic       pdown_next;
	logic [7:0] smb_reg;        // Byte toward SMBus unit
	logic [7:0] smb_next;
	logic [7:0] esp_reg;        // Byte toward eSPI unit
	logic [7:0] esp_next;
	logic       hot_reg;        // Over-temperature asserted
	logic       hot_next;
	logic       cool_ev;        // Downward cool crossing
	logic       hot_ev;         // Upward hot crossing
	logic       cata_ev;        // Upward catastrophic crossing
	logic [7:0] rpt;            // Current report byte

	// Crossing detect and next-state computation
	always_comb
	begin
		temp_next  = temp_reg;
		have_next  = have_reg;
		cool_ev    = 1'b0;
		hot_ev     = 1'b0;
		// Trip order cool < hot < fixed catastrophic point is expected of the
		// threshold ports; a misordered pair only misplaces alerts, never power down
		cata_ev    = 1'b0;
		if (sample_valid && sensor_enable)
		begin
			temp_next = sample_temp;
			have_next = 1'b1;
			// Cool and hot edges only compare against a previously held sample; with none held, catastrophic fires on any sample above 120
			if (have_reg)
			begin
				cool_ev = (temp_reg >= cool_trip) && (sample_temp < cool_trip);
				hot_ev  = (temp_reg <= hot_trip) && (sample_temp > hot_trip);
				cata_ev = (temp_reg <= `DTT_CATA_TEMP)
					&& (sample_temp > `DTT_CATA_TEMP);
			end
			else
				cata_ev = sample_temp > `DTT_CATA_TEMP;
		end
		// Only directional events reach the alert; reverse crossings are dropped
		alert_next.smi = route(cool_ev, cool_cfg).smi | route(hot_ev, hot_cfg).smi;
		alert_next.sci = route(cool_ev, cool_cfg).sci | route(hot_ev, hot_cfg).sci;
		// Power down is sticky until reset: a runaway must not be undone
		pdown_next = pdown_reg | cata_ev;
		// Report ignores alert configuration entirely
		rpt = report_byte(sensor_enable && have_next, temp_next);
		smb_next = report_enable ? rpt : `DTT_REPORT_OFF;
		esp_next = report_enable ? rpt : `DTT_REPORT_OFF;
		// Pin changes only on the evaluation tick, both set and release
		hot_next = hot_reg;
		if (eval_tick)
			hot_next = have_reg && (temp_reg > hot_pin_limit_value);
	end

	// Register all state
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			temp_reg  <= '0;
			have_reg  <= 1'b0;
			alert_reg <= '0;
			pdown_reg <= 1'b0;
			smb_reg   <= `DTT_REPORT_OFF;
			esp_reg   <= `DTT_REPORT_OFF;
			hot_reg   <= 1'b0;
		end
		else
		begin
			temp_reg  <= temp_next;
			have_reg  <= have_next;
			alert_reg <= alert_next;
			pdown_reg <= pdown_next;
			smb_reg   <= smb_next;
			esp_reg   <= esp_next;
			hot_reg   <= hot_next;
		end
	end

	// ********************************************
	// Outputs
	// ********************************************
	assign temp_value           = temp_reg;
	assign alert                = alert_reg;
	assign power_down           = pdown_reg;
	assign smbus_temp_byte      = smb_reg;
	assign espi_temp_byte       = esp_reg;
	// Open drain: data fixed low, enable carries the alarm
	assign overtemp_alert_n_out = 1'b0;
	assign overtemp_alert_n_oe  = hot_reg;

	// ********************************************
	// Checks
	// ********************************************
	chk_cool_fall: assert property (@(posedge clk_sys) disable iff (reset)
		(sample_valid && sensor_enable && have_reg && temp_reg >= cool_trip
		&& sample_temp < cool_trip && cool_cfg.enable && !cool_cfg.route_sci)
		|=> alert.smi) else $error("cool fall no smi");
	chk_hot_rise: assert property (@(posedge clk_sys) disable iff (reset)
		(sample_valid && sensor_enable && have_reg && temp_reg <= hot_trip
		&& sample_temp > hot_trip && hot_cfg.enable && hot_cfg.route_sci)
		|=> alert.sci) else $error("hot rise no sci");
	chk_no_alert_cfg: assert property (@(posedge clk_sys) disable iff (reset)
		(!cool_cfg.enable && !hot_cfg.enable) |=> (!alert.smi && !alert.sci))
		else $error("alert while disabled");
	chk_alert_quiet: assert property (@(posedge clk_sys) disable iff (reset)
		!(sample_valid && sensor_enable) |=> (!alert.smi && !alert.sci))
		else $error("alert without sample");
	// A hot fall that stays above cool can raise nothing at all
	chk_hot_fall_quiet: assert property (@(posedge clk_sys) disable iff (reset)
		(sample_valid && sensor_enable && have_reg && temp_reg > hot_trip
		&& sample_temp <= hot_trip && sample_temp >= cool_trip)
		|=> (!alert.smi && !alert.sci)) else $error("alert on hot fall");
	chk_cata_pdown: assert property (@(posedge clk_sys) disable iff (reset)
		(sample_valid && sensor_enable && sample_temp > 9'sd120)
		|=> power_down) else $error("no power down");
	chk_pdown_sticky: assert property (@(posedge clk_sys) disable iff (reset)
		power_down |=> power_down) else $error("power down dropped");
	chk_report_off: assert property (@(posedge clk_sys) disable iff (reset)
		!report_enable |=> (smbus_temp_byte == 8'hff && espi_temp_byte == 8'hff))
		else $error("report not ff");
	chk_report_same: assert property (@(posedge clk_sys) disable iff (reset)
		1'b1 |-> (smbus_temp_byte == espi_temp_byte) && (smbus_temp_byte <= 8'h7f
		|| smbus_temp_byte == 8'hff)) else $error("report mismatch");
	chk_pin_hold: assert property (@(posedge clk_sys) disable iff (reset)
		!eval_tick |=> $stable(overtemp_alert_n_oe)) else $error("pin moved");
	chk_pin_eval: assert property (@(posedge clk_sys) disable iff (reset)
		(eval_tick && have_reg) |=> (overtemp_alert_n_oe ==
		($past(temp_reg) > $past(hot_pin_limit_value)))) else $error("pin wrong");
endmodule

// file: tb/dtt_ec_model.sv
// Purpose: Controller-side model: hot pin pull-up and report byte reads
// Assumes: Reads are one-cycle requests on clk_sys
// Notes:   An idle read port toggles so stale data never looks valid
`timescale 1ns/1ns

module dtt_ec_model
(
	input  wire logic       clk_sys,
	input  wire logic       pin_oe,
	input  wire logic       pin_out,
	input  wire logic       rd_req,
	input  wire logic       rd_espi,
	input  wire logic [7:0] smbus_byte,
	input  wire logic [7:0] espi_byte,
	output logic            pin_level,
	output logic [7:0]      rd_byte
);
	// ************
	// Board side
	// ************
	// Pull-up holds the line high whenever the device lets go
	assign pin_level = pin_oe ? pin_out : 1'b1;
	// One-byte read over either channel
	always_ff @(posedge clk_sys)
		rd_byte <= rd_req ? (rd_espi ? espi_byte : smbus_byte) : ~rd_byte;
endmodule

// file: tb/dtt_trip_alert_test.sv
// Purpose: Self-checking bench for the trip and alert logic
// Assumes: Eval interval cut to 20 cycles for a short run
// Notes:   Driver queues notes; monitor pops one per taken sample
`timescale 1ns/1ns
`include "dtt_defs.svh"

module dtt_trip_alert_test;
	import dtt_pkg::*;
	// ************
	// State
	// ************
	localparam int unsigned EVAL = 20;
	localparam dtt_temp_t   COOL = 9'sd30;
	localparam dtt_temp_t   HOT  = 9'sd80;
	typedef struct packed
	{
		dtt_temp_t  t;
		logic [7:0] b;
		dtt_alert_s a;
		logic       pd;
	} dtt_note_s;
	logic          clk_sys = 1'b0;
	logic          reset   = 1'b1;
	logic          sen     = 1'b1; // Sensor on
	logic          sv      = 1'b0; // Sample strobe
	dtt_temp_t     st      = '0;
	dtt_temp_t     lim     = 9'sd60;
	dtt_trip_cfg_s ccfg    = '0;
	dtt_trip_cfg_s hcfg    = '0;
	logic          ren     = 1'b1;
	logic          rd_req  = 1'b0;
	logic          rd_espi = 1'b0;
	dtt_temp_t     temp_value;
	dtt_alert_s    alert;
	logic          power_down;
	logic [7:0]    sb;
	logic [7:0]    eb;
	logic          od_out;
	logic          od_oe;
	logic          pin;
	logic [7:0]    rd_byte;
	dtt_note_s     notes[$];
	dtt_note_s     cur;
	dtt_temp_t     ref_t;
	logic          have    = 1'b0;
	logic          pd_exp  = 1'b0;
	logic          took    = 1'b0;
	int            n_fail  = 0;
	int            checked = 0;
	time           t_up;
	dtt_temp_t     tab[10] = '{50, -5, 20, 40, 90, 70, 80, 81, 30, 29};

	dtt_trip_alert #(.EVAL_CYCLES(EVAL)) u_dut
	(
		.clk_sys(clk_sys), .reset(reset), .sensor_enable(sen), .sample_valid(sv),
		.sample_temp(st), .cool_trip(COOL), .hot_trip(HOT), .cool_cfg(ccfg),
		.hot_cfg(hcfg), .hot_pin_limit_value(lim), .report_enable(ren),
		.temp_value(temp_value), .alert(alert), .power_down(power_down),
		.smbus_temp_byte(sb), .espi_temp_byte(eb),
		.overtemp_alert_n_out(od_out), .overtemp_alert_n_oe(od_oe)
	);
	dtt_ec_model u_ec
	(
		.clk_sys(clk_sys), .pin_oe(od_oe), .pin_out(od_out), .rd_req(rd_req),
		.rd_espi(rd_espi), .smbus_byte(sb), .espi_byte(eb), .pin_level(pin),
		.rd_byte(rd_byte)
	);
	// ************
	// Helpers
	// ************
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e)
		begin
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
			n_fail++;
		end
	endtask
	task automatic conclude();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Report byte as the controller should see it
	function automatic logic [7:0] rep(input dtt_temp_t t);
		if (!ren || !have)
			return `DTT_REPORT_OFF;
		if (t < 0)
			return 8'h00;
		return (t > 127) ? `DTT_REPORT_MAX : t[7:0];
	endfunction
	function automatic dtt_alert_s route(input logic ev, input dtt_trip_cfg_s c);
		return {ev && c.enable && !c.route_sci, ev && c.enable && c.route_sci};
	endfunction
	// Called on a rising edge; leaves the strobe up for back-to-back use
	task automatic send(input dtt_temp_t t);
		dtt_note_s n;
		sv <= 1'b1;
		st <= t;
		if (sen)
		begin
			n.a = route(have && ref_t >= COOL && t < COOL, ccfg)
				| route(have && ref_t <= HOT && t > HOT, hcfg);
			pd_exp = pd_exp | ((!have || ref_t <= `DTT_CATA_TEMP) && t > `DTT_CATA_TEMP);
			have = 1'b1;
			ref_t = t;
			n.t = t;
			n.b = rep(t);
			n.pd = pd_exp;
			notes.push_back(n);
		end
		@(posedge clk_sys);
	endtask
	// Bounded wait for the pin enable, polled on falling edges
	task automatic wait_oe(input logic v);
		sv <= 1'b0;
		@(negedge clk_sys);
		for (int i = 0; i < 3 * EVAL && od_oe !== v; i++)
			@(negedge clk_sys);
		chk(od_oe, v);
		chk(pin, !v);
	endtask

	initial forever #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) took <= sv && sen && !reset;
	// Monitor: one note per taken sample, quiet alerts otherwise
	initial forever
	begin
		@(posedge clk_sys);
		#1;
		if (took && notes.size() > 0)
		begin
			cur = notes.pop_front();
			chk(temp_value, cur.t);
			chk(sb, cur.b);
			chk(eb, cur.b);
			chk(alert, cur.a);
			chk(power_down, cur.pd);
		end
		else
			chk(alert, '0);
	end
	initial
	begin
		repeat (2000) @(posedge clk_sys);
		n_fail++;
		conclude();
	end
	initial
	begin
		void'($urandom(53));
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		rd_req <= 1'b1;
		rd_espi <= 1'($urandom_range(1));
		@(posedge clk_sys);
		rd_req <= 1'b0;
		@(negedge clk_sys);
		chk(rd_byte, `DTT_REPORT_OFF);
		chk(od_oe, 1'b0);
		@(posedge clk_sys);
		// Every enable and route mix over crossings, boundaries included
		// Last round has both trips disabled, so crossings must stay silent
		for (int k = 0; k < 5; k++)
		begin
			sv <= 1'b0;
			ccfg <= dtt_trip_cfg_s'((k < 4) ? 2'(k) : 2'h0);
			hcfg <= dtt_trip_cfg_s'((k < 4) ? 2'(3 - k) : 2'h0);
			@(posedge clk_sys);
			foreach (tab[i])
				send(tab[i]);
		end
		sv <= 1'b0;
		ren <= 1'b0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(sb, `DTT_REPORT_OFF);
		@(posedge clk_sys);
		send(9'sd55);
		sv <= 1'b0;
		ren <= 1'b1;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(eb, 8'h37);
		@(posedge clk_sys);
		sen <= 1'b0;
		@(posedge clk_sys);
		send(9'sd100);
		sv <= 1'b0;
		sen <= 1'b1;
		@(negedge clk_sys);
		chk(temp_value, 9'sd55);
		chk(sb, `DTT_REPORT_OFF);
		@(posedge clk_sys);
		// Random temperatures at or under the limit keep the pin released
		repeat (20) send(dtt_temp_t'($urandom_range(100)) - 9'sd40);
		send(9'sd70);
		wait_oe(1'b1);
		t_up = $time;
		@(posedge clk_sys);
		send(lim);
		wait_oe(1'b0);
		chk(16'(($time - t_up) / 100), 16'(EVAL));
		@(posedge clk_sys);
		send(9'sd120);
		send(9'sd121);
		send(9'sd200);
		sv <= 1'b0;
		repeat (2) @(posedge clk_sys);
		conclude();
	end
endmodule
